// ==== logic/adcsq_top.sv ====
// sample sequencer control with apb registers and result fifos
`timescale 1ns/1ns
`include "adcsq_defines.svh"
module adcsq_top (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irqOut,
    input wire logic [3:0] extTrigger,
    output adcsq_pkg::adcsq_conv_t convReq,
    input wire logic convDone,
    input wire logic [9:0] convData
);
    localparam logic [3:0] DEPTH [4] = '{`ADCSQ_DEPTH0, `ADCSQ_DEPTH1, `ADCSQ_DEPTH2, `ADCSQ_DEPTH3};
    localparam logic [2:0] DIV_LAST = 3'(`ADCSQ_DIV - 1);

    adcsq_pkg::adcsq_state_t st_ff;
    adcsq_pkg::adcsq_state_t nxt_st;

    logic setup, wrEn, rdEn, bankHit, found;
    logic [1:0] bank, regSel, best;
    logic [3:0] code, curCtl, bestPri;
    logic [6:0] avgLast;
    logic [9:0] sample;
    logic [15:0] sum;

    // ************************************************************
    // bus decode
    // ************************************************************
    assign bank = 2'(paddr[7:5] - `ADCSQ_BANK0);
    assign regSel = paddr[3:2];
    assign bankHit = (paddr[11:8] == 4'h0) && (paddr[7:5] >= `ADCSQ_BANK0)
        && (paddr[7:5] <= `ADCSQ_BANK3) && (paddr[4] == 1'b0);
    assign setup = psel & ~penable;
    assign wrEn = psel & penable & st_ff.pready & pwrite;
    assign rdEn = psel & penable & st_ff.pready & ~pwrite;
    assign curCtl = st_ff.ctl[st_ff.cur][{st_ff.step, 2'b00} +: 4];

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        nxt_st = st_ff;
        nxt_st.conv.start = 1'b0;
        nxt_st.pready = setup;
        nxt_st.pslverr = 1'b0;
        found = 1'b0;
        best = 2'h0;
        bestPri = 4'hf;
        code = 4'h0;
        sample = 10'h000;
        sum = 16'h0000;
        avgLast = 7'(7'h01 << st_ff.sac) - 7'h01;

        // adc rate enable
        nxt_st.tick = 1'b0;
        if (st_ff.divCnt == DIV_LAST) begin
            nxt_st.divCnt = 3'h0;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.divCnt = st_ff.divCnt + 3'h1;
        end

        // read data is fetched in the setup cycle
        if (setup) begin
            nxt_st.prdata = 32'h0000_0000;
            case (paddr)
                `ADCSQ_OFF_ACTIVE: nxt_st.prdata[3:0] = st_ff.active;
                `ADCSQ_OFF_RAW: nxt_st.prdata[3:0] = st_ff.ris;
                `ADCSQ_OFF_GATE: nxt_st.prdata[3:0] = st_ff.im;
                `ADCSQ_OFF_CLEAR: nxt_st.prdata[3:0] = st_ff.ris & st_ff.im;
                `ADCSQ_OFF_OVF: nxt_st.prdata[3:0] = st_ff.ostat;
                `ADCSQ_OFF_TRIG: nxt_st.prdata[15:0] = st_ff.emux;
                `ADCSQ_OFF_UNF: nxt_st.prdata[3:0] = st_ff.ustat;
                `ADCSQ_OFF_PRI: nxt_st.prdata[15:0] = st_ff.pri;
                `ADCSQ_OFF_INIT: nxt_st.prdata = 32'h0000_0000;
                `ADCSQ_OFF_AVG: nxt_st.prdata[2:0] = st_ff.sac;
                `ADCSQ_OFF_LOOP: nxt_st.prdata[0] = st_ff.loop;
                default: begin
                    if (bankHit) begin
                        case (regSel)
                            `ADCSQ_REG_MUX: nxt_st.prdata = st_ff.mux[bank];
                            `ADCSQ_REG_CTL: nxt_st.prdata = st_ff.ctl[bank];
                            `ADCSQ_REG_POP: begin
                                if (st_ff.count[bank] != 4'h0) begin
                                    nxt_st.prdata[9:0] = st_ff.mem[bank][st_ff.tail[bank]];
                                end
                            end
                            default: begin
                                nxt_st.prdata[3:0] = {1'b0, st_ff.tail[bank]};
                                nxt_st.prdata[7:4] = {1'b0, st_ff.head[bank]};
                                nxt_st.prdata[`ADCSQ_FS_EMPTY] = (st_ff.count[bank] == 4'h0);
                                nxt_st.prdata[`ADCSQ_FS_FULL] = (st_ff.count[bank] == DEPTH[bank]);
                            end
                        endcase
                    end else begin
                        nxt_st.pslverr = 1'b1;
                    end
                end
            endcase
        end

        // register writes at the access edge
        if (wrEn) begin
            case (paddr)
                `ADCSQ_OFF_ACTIVE: nxt_st.active = pwdata[3:0];
                `ADCSQ_OFF_GATE: nxt_st.im = pwdata[3:0];
                `ADCSQ_OFF_CLEAR: nxt_st.ris = st_ff.ris & ~pwdata[3:0];
                `ADCSQ_OFF_OVF: nxt_st.ostat = st_ff.ostat & ~pwdata[3:0];
                `ADCSQ_OFF_UNF: nxt_st.ustat = st_ff.ustat & ~pwdata[3:0];
                `ADCSQ_OFF_TRIG: nxt_st.emux = pwdata[15:0];
                `ADCSQ_OFF_PRI: nxt_st.pri = pwdata[15:0] & `ADCSQ_PRI_MASK;
                `ADCSQ_OFF_AVG: begin
                    if (pwdata[2:0] > `ADCSQ_AVG_MAX) begin
                        nxt_st.sac = `ADCSQ_AVG_MAX;
                    end else begin
                        nxt_st.sac = pwdata[2:0];
                    end
                end
                `ADCSQ_OFF_LOOP: nxt_st.loop = pwdata[0];
                default: begin
                    if (bankHit && regSel == `ADCSQ_REG_MUX) begin
                        nxt_st.mux[bank] = pwdata;
                    end
                    if (bankHit && regSel == `ADCSQ_REG_CTL) begin
                        nxt_st.ctl[bank] = pwdata;
                    end
                end
            endcase
        end

        // sequencing engine
        case (st_ff.fsm)
            adcsq_pkg::ST_IDLE: begin
                for (int i = 3; i >= 0; i--) begin
                    if (st_ff.pend[i] && st_ff.active[i] && (!found || {2'b00, st_ff.pri[i * 4 +: 2]} <= bestPri)) begin
                        found = 1'b1;
                        best = 2'(i);
                        bestPri = {2'b00, st_ff.pri[i * 4 +: 2]};
                    end
                end
                if (st_ff.tick && found) begin
                    nxt_st.cur = best;
                    nxt_st.step = 3'h0;
                    nxt_st.avgCnt = 7'h00;
                    nxt_st.acc = 16'h0000;
                    nxt_st.fsm = adcsq_pkg::ST_START;
                end
            end
            adcsq_pkg::ST_START: begin
                if (st_ff.tick) begin
                    nxt_st.conv.start = ~st_ff.loop;
                    nxt_st.conv.pin = st_ff.mux[st_ff.cur][{st_ff.step, 2'b00} +: 4];
                    nxt_st.conv.diff = curCtl[`ADCSQ_CTL_DIFF];
                    nxt_st.conv.temp = curCtl[`ADCSQ_CTL_TEMP];
                    nxt_st.fsm = adcsq_pkg::ST_WAIT;
                end
            end
            adcsq_pkg::ST_WAIT: begin
                if (st_ff.loop) begin
                    sample = {st_ff.cur, st_ff.step, st_ff.avgCnt[4:0]};
                end else begin
                    sample = convData;
                end
                if (st_ff.loop ? st_ff.tick : convDone) begin
                    sum = st_ff.acc + {6'h00, sample};
                    nxt_st.acc = sum;
                    if (st_ff.avgCnt == avgLast) begin
                        nxt_st.fsm = adcsq_pkg::ST_STORE;
                    end else begin
                        nxt_st.avgCnt = st_ff.avgCnt + 7'h01;
                        nxt_st.fsm = adcsq_pkg::ST_START;
                    end
                end
            end
            adcsq_pkg::ST_STORE: begin
                if (st_ff.count[st_ff.cur] == DEPTH[st_ff.cur]) begin
                    nxt_st.ostat[st_ff.cur] = 1'b1;
                end else begin
                    nxt_st.mem[st_ff.cur][st_ff.head[st_ff.cur]] = 10'(st_ff.acc >> st_ff.sac);
                    nxt_st.count[st_ff.cur] = st_ff.count[st_ff.cur] + 4'h1;
                    if ({1'b0, st_ff.head[st_ff.cur]} == DEPTH[st_ff.cur] - 4'h1) begin
                        nxt_st.head[st_ff.cur] = 3'h0;
                    end else begin
                        nxt_st.head[st_ff.cur] = st_ff.head[st_ff.cur] + 3'h1;
                    end
                end
                if (curCtl[`ADCSQ_CTL_IE]) begin
                    nxt_st.ris[st_ff.cur] = 1'b1;
                end
                if (curCtl[`ADCSQ_CTL_END] || {1'b0, st_ff.step} == DEPTH[st_ff.cur] - 4'h1) begin
                    nxt_st.pend[st_ff.cur] = 1'b0;
                    nxt_st.fsm = adcsq_pkg::ST_IDLE;
                end else begin
                    nxt_st.step = st_ff.step + 3'h1;
                    nxt_st.avgCnt = 7'h00;
                    nxt_st.acc = 16'h0000;
                    nxt_st.fsm = adcsq_pkg::ST_START;
                end
            end
            default: nxt_st.fsm = adcsq_pkg::ST_IDLE;
        endcase

        // pop of a result word at the access edge
        if (rdEn && bankHit && regSel == `ADCSQ_REG_POP) begin
            if (st_ff.count[bank] == 4'h0) begin
                nxt_st.ustat[bank] = 1'b1;
            end else begin
                nxt_st.count[bank] = nxt_st.count[bank] - 4'h1;
                if ({1'b0, st_ff.tail[bank]} == DEPTH[bank] - 4'h1) begin
                    nxt_st.tail[bank] = 3'h0;
                end else begin
                    nxt_st.tail[bank] = st_ff.tail[bank] + 3'h1;
                end
            end
        end

        // trigger capture, set wins over completion
        for (int i = 0; i < 4; i++) begin
            code = st_ff.emux[i * 4 +: 4];
            if (st_ff.active[i] && ((code == `ADCSQ_TRIG_ALWAYS)
                || (code == `ADCSQ_TRIG_SW && wrEn && paddr == `ADCSQ_OFF_INIT && pwdata[i])
                || (code != `ADCSQ_TRIG_SW && code <= `ADCSQ_TRIG_EXT_N && extTrigger[2'(code - 4'h1)]))) begin
                nxt_st.pend[i] = 1'b1;
            end
            if (!nxt_st.active[i]) begin
                nxt_st.pend[i] = 1'b0;
            end
        end
        nxt_st.irq = |(nxt_st.ris & nxt_st.im);
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
            st_ff.pri <= `ADCSQ_PRI_RESET;
            st_ff.ctl[3] <= `ADCSQ_CTL3_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;
    assign irqOut = st_ff.irq;
    assign convReq = st_ff.conv;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    property p_depth;
        st_ff.count[0] <= `ADCSQ_DEPTH0 && st_ff.count[1] <= `ADCSQ_DEPTH1
            && st_ff.count[2] <= `ADCSQ_DEPTH2 && st_ff.count[3] <= `ADCSQ_DEPTH3;
    endproperty
    a_depth: assert property (p_depth) else $error("fifo count beyond depth");

    property p_low_bits;
        rdEn && bankHit && regSel == `ADCSQ_REG_POP |-> prdata[31:10] == 22'h000000;
    endproperty
    a_low_bits: assert property (p_low_bits) else $error("result upper bits not zero");

    property p_pin;
        convReq.start |-> convReq.pin == st_ff.mux[st_ff.cur][{st_ff.step, 2'b00} +: 4];
    endproperty
    a_pin: assert property (p_pin) else $error("converter pin differs from step nibble");

    property p_disabled_idle;
        st_ff.fsm == adcsq_pkg::ST_IDLE && !(|(st_ff.pend & st_ff.active)) |=> st_ff.fsm == adcsq_pkg::ST_IDLE;
    endproperty
    a_disabled_idle: assert property (p_disabled_idle) else $error("started without trigger");

    property p_raw_irq;
        st_ff.fsm == adcsq_pkg::ST_STORE && curCtl[`ADCSQ_CTL_IE] |=> st_ff.ris[$past(st_ff.cur)];
    endproperty
    a_raw_irq: assert property (p_raw_irq) else $error("raw interrupt not raised");

    property p_end_stop;
        st_ff.fsm == adcsq_pkg::ST_STORE && curCtl[`ADCSQ_CTL_END] |=> st_ff.fsm == adcsq_pkg::ST_IDLE;
    endproperty
    a_end_stop: assert property (p_end_stop) else $error("sequence ran past end step");

    property p_underflow;
        rdEn && bankHit && regSel == `ADCSQ_REG_POP && st_ff.count[bank] == 4'h0 |=> st_ff.ustat[$past(bank)];
    endproperty
    a_underflow: assert property (p_underflow) else $error("underflow not recorded");

    property p_tick;
        st_ff.tick |=> !st_ff.tick [*5] ##1 st_ff.tick;
    endproperty
    a_tick: assert property (p_tick) else $error("adc tick spacing wrong");

    property p_irq_line;
        ##1 irqOut == |(st_ff.ris & st_ff.im);
    endproperty
    a_irq_line: assert property (p_irq_line) else $error("interrupt line not raw and gate");

    property p_clear;
        wrEn && paddr == `ADCSQ_OFF_CLEAR && pwdata[0] && st_ff.fsm != adcsq_pkg::ST_STORE |=> !st_ff.ris[0];
    endproperty
    a_clear: assert property (p_clear) else $error("write one did not clear");

    property p_pop_empty;
        setup && bankHit && regSel == `ADCSQ_REG_POP && st_ff.count[bank] == 4'h0 |=> prdata == 32'h0000_0000;
    endproperty
    a_pop_empty: assert property (p_pop_empty) else $error("empty pop returned data");

    property p_empty_flag;
        setup && bankHit && regSel == `ADCSQ_REG_STAT
            |=> prdata[`ADCSQ_FS_EMPTY] == ($past(st_ff.count[bank]) == 4'h0);
    endproperty
    a_empty_flag: assert property (p_empty_flag) else $error("empty flag wrong");

    property p_ovf_set;
        st_ff.fsm == adcsq_pkg::ST_STORE && st_ff.count[st_ff.cur] == DEPTH[st_ff.cur]
            |=> st_ff.ostat[$past(st_ff.cur)];
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow not recorded");

    property p_prio_pick;
        st_ff.fsm == adcsq_pkg::ST_IDLE && st_ff.tick && (st_ff.pend & st_ff.active) == 4'h6
            && st_ff.pri[9:8] < st_ff.pri[5:4] |=> st_ff.cur == 2'h2;
    endproperty
    a_prio_pick: assert property (p_prio_pick) else $error("lower priority served first");

    property p_always;
        !wrEn && st_ff.active[3] && st_ff.emux[15:12] == `ADCSQ_TRIG_ALWAYS |=> st_ff.pend[3];
    endproperty
    a_always: assert property (p_always) else $error("always trigger not pending");

    property p_soft_init;
        wrEn && paddr == `ADCSQ_OFF_INIT && pwdata[0] && st_ff.active[0] && st_ff.emux[3:0] == `ADCSQ_TRIG_SW
            |=> st_ff.pend[0];
    endproperty
    a_soft_init: assert property (p_soft_init) else $error("software initiate ignored");

    property p_avg_off;
        st_ff.fsm == adcsq_pkg::ST_STORE && st_ff.sac == 3'h0 |-> st_ff.avgCnt == 7'h00;
    endproperty
    a_avg_off: assert property (p_avg_off) else $error("several samples stored with averaging off");

    property p_loop_quiet;
        st_ff.loop |=> !convReq.start;
    endproperty
    a_loop_quiet: assert property (p_loop_quiet) else $error("converter started in loopback");

    property p_first_step;
        st_ff.fsm == adcsq_pkg::ST_IDLE ##1 st_ff.fsm == adcsq_pkg::ST_START |-> st_ff.step == 3'h0;
    endproperty
    a_first_step: assert property (p_first_step) else $error("sequence did not start at first step");

    property p_pend_enabled;
        (st_ff.pend & ~st_ff.active) == 4'h0;
    endproperty
    a_pend_enabled: assert property (p_pend_enabled) else $error("trigger pending on disabled sequencer");

    c_end: cover property (st_ff.fsm == adcsq_pkg::ST_STORE && curCtl[`ADCSQ_CTL_END]);
    c_ovf: cover property ($rose(st_ff.ostat[0]));
    c_avg: cover property (st_ff.fsm == adcsq_pkg::ST_STORE && st_ff.sac != 3'h0);
    c_loop: cover property (st_ff.loop && st_ff.fsm == adcsq_pkg::ST_STORE);
    c_prio: cover property (st_ff.fsm == adcsq_pkg::ST_IDLE && st_ff.tick && (st_ff.pend & st_ff.active) == 4'h6);
endmodule : adcsq_top

// ==== logic/adcsq_defines.svh ====
// register offsets, field positions, reset values and timing counts of the sequencer block
// How it works
// - four sequencers, depths eight four four one
// - fifo word 32 bits, result low ten
// - each step: input nibble plus control nibble
// - starts only when enabled, configurable while off
// - same input may repeat within sequence
// - raw interrupt after each enabled step
// - end marker stops sequence after that step
// - circular fifo, each read pops oldest
// - status shows pointers, full and empty
// - overflow and underflow recorded per sequencer
// - control runs on divided 16.667 MHz tick
// - masked status is raw and gate
// - write one clears interrupt, zero ignored
// - concurrent triggers served by priority value
// - trigger source selected per sequencer
// - software initiate bit starts selected sequencer
// - one averager accumulates up to 64
// - averaging off after reset, same for all
// - loopback mode feeds digital data back
// - reset priority zero highest three lowest
`ifndef ADCSQ_DEFINES_SVH
`define ADCSQ_DEFINES_SVH
`define ADCSQ_OFF_ACTIVE 12'h000
`define ADCSQ_OFF_RAW 12'h004
`define ADCSQ_OFF_GATE 12'h008
`define ADCSQ_OFF_CLEAR 12'h00c
`define ADCSQ_OFF_OVF 12'h010
`define ADCSQ_OFF_TRIG 12'h014
`define ADCSQ_OFF_UNF 12'h018
`define ADCSQ_OFF_PRI 12'h020
`define ADCSQ_OFF_INIT 12'h028
`define ADCSQ_OFF_AVG 12'h030
`define ADCSQ_OFF_LOOP 12'h100
`define ADCSQ_BANK0 3'h2
`define ADCSQ_BANK3 3'h5
`define ADCSQ_REG_MUX 2'h0
`define ADCSQ_REG_CTL 2'h1
`define ADCSQ_REG_POP 2'h2
`define ADCSQ_REG_STAT 2'h3
`define ADCSQ_PRI_RESET 16'h3210
`define ADCSQ_PRI_MASK 16'h3333
`define ADCSQ_CTL3_RESET 32'h0000_0002
`define ADCSQ_CTL_DIFF 0
`define ADCSQ_CTL_END 1
`define ADCSQ_CTL_IE 2
`define ADCSQ_CTL_TEMP 3
`define ADCSQ_FS_EMPTY 8
`define ADCSQ_FS_FULL 12
`define ADCSQ_TRIG_SW 4'h0
`define ADCSQ_TRIG_ALWAYS 4'hf
`define ADCSQ_TRIG_EXT_N 4'h4
`define ADCSQ_AVG_MAX 3'h6
`define ADCSQ_DEPTH0 4'h8
`define ADCSQ_DEPTH1 4'h4
`define ADCSQ_DEPTH2 4'h4
`define ADCSQ_DEPTH3 4'h1
`define ADCSQ_SYS_KHZ 100000
`define ADCSQ_ADC_KHZ 16667
`define ADCSQ_DIV ((`ADCSQ_SYS_KHZ + `ADCSQ_ADC_KHZ / 2) / `ADCSQ_ADC_KHZ)
`endif

// ==== logic/adcsq_pkg.sv ====
// types shared by the sequencer block
package adcsq_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_START = 2'b01,
        ST_WAIT = 2'b11,
        ST_STORE = 2'b10
    } adcsq_fsm_t;
    typedef struct packed {
        logic start;
        logic [3:0] pin;
        logic diff;
        logic temp;
    } adcsq_conv_t;
    typedef struct packed {
        adcsq_fsm_t fsm;
        logic [2:0] divCnt;
        logic tick;
        logic [3:0] active, ris, im, ostat, ustat, pend;
        logic [15:0] emux, pri;
        logic [2:0] sac;
        logic loop;
        logic [3:0][31:0] mux, ctl;
        logic [3:0][2:0] head, tail;
        logic [3:0][3:0] count;
        logic [3:0][7:0][9:0] mem;
        logic [1:0] cur;
        logic [2:0] step;
        logic [6:0] avgCnt;
        logic [15:0] acc;
        adcsq_conv_t conv;
        logic [31:0] prdata;
        logic pready, pslverr, irq;
    } adcsq_state_t;
endpackage : adcsq_pkg

// ==== tb/adcsq_conv_model.sv ====
// converter core model answering conversion requests
`timescale 1ns/1ns
module adcsq_conv_model (
    input wire logic clk,
    input wire logic reset,
    input wire adcsq_pkg::adcsq_conv_t convReq,
    output logic convDone,
    output logic [9:0] convData
);
    // ****************************************
    // answer after a random delay, then scramble data
    // ****************************************
    logic [3:0] pin;
    initial begin
        convDone = 1'b0;
        convData = 10'h2aa;
        forever begin
            @(posedge clk);
            if (reset === 1'b0 && convReq.start === 1'b1) begin
                pin = convReq.pin;
                repeat ($urandom_range(12, 0)) @(posedge clk);
                convDone <= 1'b1;
                convData <= {6'h15, pin};
                @(posedge clk);
                convDone <= 1'b0;
                convData <= ~{6'h15, pin};
            end
        end
    end
endmodule : adcsq_conv_model

// ==== tb/adcsq_top_tb.sv ====
// self-checking bench for the sample sequencer block
`timescale 1ns/1ns
`include "adcsq_defines.svh"
module adcsq_top_tb;
    logic clk, reset, psel, penable, pwrite, pready, pslverr, irqOut, convDone, rdErr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, mux0;
    logic [3:0] extTrigger, m3;
    logic [9:0] convData;
    logic [5:0] pins[$];
    adcsq_pkg::adcsq_conv_t convReq;
    int nMismatch = 0;
    int nTests = 0;
    int nStarts = 0;
    adcsq_top dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irqOut(irqOut), .extTrigger(extTrigger), .convReq(convReq), .convDone(convDone),
        .convData(convData));
    adcsq_conv_model conv (.clk(clk), .reset(reset), .convReq(convReq), .convDone(convDone),
        .convData(convData));
    // ****************************************
    // clock, start monitor, bus tasks
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (convReq.start === 1'b1) begin
            nStarts++;
            pins.push_back({convReq.temp, convReq.diff, convReq.pin});
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            nMismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask : rdc
    task automatic waitFor(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
        int n;
        n = 0;
        do begin
            apb(1'b0, a, 32'h0);
            n++;
        end while ((rd & m) !== v && n < 300);
        chk("poll", rd & m, v);
    endtask : waitFor
    function automatic logic [11:0] bk(input int s, input int r);
        return 12'h040 + 12'(s * 32 + r * 4);
    endfunction : bk
    function automatic logic [31:0] res(input logic [3:0] p);
        return {22'h0, 6'h15, p};
    endfunction : res
    task automatic testDone;
        if (nMismatch == 0 && nTests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : testDone
    initial begin
        repeat (40000) @(posedge clk);
        nMismatch++;
        testDone();
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        int s;
        void'($urandom(32'h9ff621a2));
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        extTrigger = 4'h0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rdc(`ADCSQ_OFF_PRI, 32'h3210, "priority reset");
        rdc(bk(3, 1), 32'h2, "ctl3 reset");
        rdc(`ADCSQ_OFF_AVG, 32'h0, "averaging reset");
        wr(`ADCSQ_OFF_AVG, 32'h7);
        rdc(`ADCSQ_OFF_AVG, 32'h6, "averaging clamp");
        wr(`ADCSQ_OFF_AVG, 32'h0);
        for (s = 0; s < 4; s++)
            rdc(bk(s, 3), 32'h100, "fifo status reset");
        apb(1'b0, 12'h200, 32'h0);
        chk("unmapped error", {31'h0, rdErr}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b0, 12'h0c8, 32'h0);
        chk("alias error", {31'h0, rdErr}, 32'h1);
        mux0 = $urandom();
        mux0[7:4] = mux0[3:0];
        wr(bk(0, 0), mux0);
        rdc(bk(0, 0), mux0, "mux while disabled");
        wr(bk(0, 1), 32'h4006_0040);
        wr(`ADCSQ_OFF_INIT, 32'h1);
        repeat (40) @(posedge clk);
        rdc(bk(0, 3), 32'h100, "idle while disabled");
        wr(`ADCSQ_OFF_ACTIVE, 32'h1);
        wr(`ADCSQ_OFF_INIT, 32'h1);
        waitFor(bk(0, 3), 32'hfff, 32'h050);
        repeat (80) @(posedge clk);
        rdc(bk(0, 3), 32'h050, "stop at end marker");
        rdc(`ADCSQ_OFF_RAW, 32'h1, "raw after sample");
        rdc(`ADCSQ_OFF_CLEAR, 32'h0, "masked gated off");
        chk("irq gated off", {31'h0, irqOut}, 32'h0);
        wr(`ADCSQ_OFF_GATE, 32'h1);
        rdc(`ADCSQ_OFF_CLEAR, 32'h1, "masked gated on");
        chk("irq gated on", {31'h0, irqOut}, 32'h1);
        wr(`ADCSQ_OFF_CLEAR, 32'he);
        rdc(`ADCSQ_OFF_RAW, 32'h1, "zero write kept");
        wr(`ADCSQ_OFF_CLEAR, 32'h1);
        rdc(`ADCSQ_OFF_RAW, 32'h0, "one write clears");
        chk("irq cleared", {31'h0, irqOut}, 32'h0);
        for (s = 0; s < 5; s++)
            rdc(bk(0, 2), res(mux0[4 * s +: 4]), "fifo order");
        rdc(bk(0, 3), 32'h155, "drained status");
        rdc(bk(0, 2), 32'h0, "empty pop");
        rdc(`ADCSQ_OFF_UNF, 32'h1, "underflow");
        wr(`ADCSQ_OFF_UNF, 32'h1);
        wr(`ADCSQ_OFF_ACTIVE, 32'h0);
        wr(`ADCSQ_OFF_GATE, 32'h0);
        wr(bk(1, 0), 32'h1111);
        wr(bk(1, 1), 32'hb);
        wr(bk(2, 0), 32'h2222);
        wr(bk(2, 1), 32'h2);
        wr(`ADCSQ_OFF_PRI, 32'h3120);
        pins.delete();
        wr(`ADCSQ_OFF_ACTIVE, 32'h6);
        wr(`ADCSQ_OFF_INIT, 32'h6);
        waitFor(bk(1, 3), 32'hfff, 32'h010);
        chk("first served", {26'h0, pins[0]}, 32'h2);
        chk("second served", {26'h0, pins[1]}, 32'h31);
        rdc(bk(2, 2), res(4'h2), "seq2 result");
        wr(`ADCSQ_OFF_ACTIVE, 32'h0);
        wr(`ADCSQ_OFF_PRI, 32'h3210);
        m3 = 4'($urandom());
        wr(bk(3, 0), {28'h0, m3});
        wr(`ADCSQ_OFF_TRIG, 32'h1000);
        wr(`ADCSQ_OFF_AVG, 32'h2);
        wr(`ADCSQ_OFF_ACTIVE, 32'h8);
        nStarts = 0;
        extTrigger <= 4'h1;
        repeat (2) @(posedge clk);
        extTrigger <= 4'h0;
        waitFor(bk(3, 3), 32'h1000, 32'h1000);
        chk("averaged count", 32'(nStarts), 32'h4);
        rdc(bk(3, 2), res(m3), "averaged result");
        wr(`ADCSQ_OFF_AVG, 32'h0);
        wr(`ADCSQ_OFF_TRIG, 32'h0);
        wr(`ADCSQ_OFF_LOOP, 32'h1);
        nStarts = 0;
        wr(`ADCSQ_OFF_INIT, 32'h8);
        waitFor(bk(3, 3), 32'h1000, 32'h1000);
        chk("loopback starts", 32'(nStarts), 32'h0);
        rdc(bk(3, 2), 32'h300, "loopback word");
        wr(`ADCSQ_OFF_LOOP, 32'h0);
        wr(`ADCSQ_OFF_TRIG, 32'hf000);
        waitFor(`ADCSQ_OFF_OVF, 32'h8, 32'h8);
        wr(`ADCSQ_OFF_ACTIVE, 32'h0);
        testDone();
    end
endmodule : adcsq_top_tb
